//--- hw/hap_ctrl_pkg.sv
// Purpose: Shared constants and types of the haptic control block
// Assumes: 50 MHz core clock, 8-bit register port
// Notes: Offsets are the register addresses seen over I2C
package hap_ctrl_pkg;

  // ---------------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_FAULT_STATUS = 8'h00;
  localparam logic [7:0] ADDR_MODE_CONTROL = 8'h01;
  localparam logic [7:0] ADDR_LAUNCH_CONTROL = 8'h0c;
  localparam logic [7:0] ADDR_CFG_FIRST = 8'h16;
  localparam logic [7:0] ADDR_CFG_LAST = 8'h1a;
  localparam logic [7:0] ADDR_LOOP_CONTROL = 8'h1d;
  localparam logic [7:0] ADDR_SUPPLY = 8'h21;
  localparam int CFG_COUNT = 5;

  // ---------------------------------------------------------------
  // Field positions and reset values
  // ---------------------------------------------------------------
  localparam int MODE_RESET_BIT = 7;
  localparam int MODE_STANDBY_BIT = 6;
  localparam int FAULT_OC_BIT = 0;
  localparam int FAULT_THERM_BIT = 1;
  localparam logic [7:0] MODE_RESET = 8'h40;
  localparam logic [7:0] LOOP_RESET = 8'h00;
  localparam logic [39:0] CFG_RESET = 40'h00_00_00_00_00;

  // Noise gate floors for gate_threshold 1..3 (0 = gate off)
  localparam logic [7:0] GATE_FLOOR_1 = 8'h04;
  localparam logic [7:0] GATE_FLOOR_2 = 8'h08;
  localparam logic [7:0] GATE_FLOOR_3 = 8'h0c;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLOCK_PERIOD_NS = 20;
  localparam int HANG_TIME_NS = 4330000;
  localparam int HANG_CYCLES = HANG_TIME_NS / CLOCK_PERIOD_NS;

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    MODE_INTERNAL = 3'b000,
    MODE_EDGE = 3'b001,
    MODE_LEVEL = 3'b010,
    MODE_ANALOG_PWM = 3'b011,
    MODE_RTP = 3'b101,
    MODE_DIAG = 3'b110,
    MODE_CAL = 3'b111
  } hap_mode_e;

  typedef enum logic [2:0] {
    PWR_SHUTDOWN = 3'b000,
    PWR_STANDBY = 3'b001,
    PWR_READY = 3'b010,
    PWR_PLAYING = 3'b011,
    PWR_FAULT = 3'b100
  } hap_power_e;

  // One register access from the I2C front end
  typedef struct packed {
    logic write;
    logic read;
    logic [7:0] addr;
    logic [7:0] wdata;
  } hap_reg_req_s;

  // Analog fault monitors
  typedef struct packed {
    logic overTemp;
    logic outputShort;
    logic regShort;
    logic brownout;
  } hap_fault_s;

endpackage

//--- hw/hap_ctrl_top.sv
// Purpose: Trigger, power-state and fault control of a haptic driver
// Assumes: Register port comes from an I2C slave front end
// Notes: Waveform engine and drive loop are outside this block

// Summary of operation
// - Launch bit starts playback, clearing cancels
// - Edge mode: trigger rise sets launch bit
// - Edge mode: rise while launched cancels
// - Edge mode: trigger fall does nothing
// - Level mode: launch bit tracks trigger pin
// - Noise gate suppresses input below threshold
// - Supply sampled into register during playback
// - Configuration registers reload from OTP
// - Hung I2C transfer reset after 4.33 ms
// - Hang watchdog idle during standby
// - Overheat shuts down, sets thermal flag
// - Output short latches flag, restarts defaults
// - Regulator short disables, then resets defaults
// - Brownout shuts down, then resets defaults
// - Enable low means shutdown, registers kept
// - Enable low ignores register reads, writes
// - Standby set after reset, keeps registers
// - Standby stops playback; clearing gives ready
// - Soft reset restores defaults, self-clears
// - Internal mode launch stays high until done
// - Only level mode mirrors trigger in launch bit
module hap_ctrl_top #(
  parameter int HANG_TIMEOUT_CYCLES = hap_ctrl_pkg::HANG_CYCLES
) (
  // Clock and reset
  input wire logic clock,
  input wire logic reset,
  // Host pins
  input wire logic enablePin,
  input wire logic triggerInputPin,
  // Register port from the I2C slave
  input wire hap_ctrl_pkg::hap_reg_req_s regReq,
  input wire logic i2cBusy,
  output logic [7:0] regReadData,
  output logic i2cProtocolReset,
  // Playback engine
  input wire logic sequenceDone,
  input wire logic [7:0] inputLevel,
  output logic playbackRun,
  output logic [7:0] gatedLevel,
  output logic [7:0] modeControl,
  output logic [7:0] loopControl,
  output logic [39:0] configImage,
  output hap_ctrl_pkg::hap_power_e powerState,
  // Analog monitors and OTP
  input wire logic [7:0] supplyLevel,
  input wire hap_ctrl_pkg::hap_fault_s faultIn,
  input wire logic otpProgrammed,
  input wire logic [39:0] otpImage
);

  // ---------------------------------------------------------------
  // Decoding helper
  // ---------------------------------------------------------------

  // True for an address inside the OTP-backed window
  function automatic logic isCfg(input logic [7:0] a);
    isCfg = (a >= hap_ctrl_pkg::ADDR_CFG_FIRST) && (a <= hap_ctrl_pkg::ADDR_CFG_LAST);
  endfunction

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  logic [6:0] modeControl_reg; // Standby bit and mode field
  logic softResetReq_reg; // Soft reset in progress
  logic launch_reg; // Launch bit, also runs playback
  logic [7:0] loopControl_reg; // Loop control incl. gate_threshold
  logic [7:0] supplyReading_reg; // Latest supply sample
  logic [1:0] faultStatus_reg; // Sticky fault flags
  logic [7:0] regReadData_reg; // Read answer
  logic [7:0] gatedLevel_reg; // Gated input level
  logic resetFaultPrev_reg; // Reset-type fault seen last cycle
  logic recoverReq_reg; // Fault just removed
  logic otpLoad_reg; // First cycle after a reset
  logic [7:0] cfg_reg [hap_ctrl_pkg::CFG_COUNT]; // OTP-backed settings
  hap_ctrl_pkg::hap_power_e powerState_reg;

  // ---------------------------------------------------------------
  // Resets
  // ---------------------------------------------------------------
  logic coreReset; // Control, measurement and config registers back to defaults
  logic statusReset; // Clears fault flags too
  logic faultHold; // Any fault keeps the device down
  logic resetFaultNow; // Faults that end in a restart

  assign resetFaultNow = faultIn.outputShort | faultIn.regShort | faultIn.brownout;
  assign faultHold = faultIn.overTemp | resetFaultNow;
  // Status survives fault restarts so the host can still see why
  assign statusReset = reset | softResetReq_reg;
  assign coreReset = statusReset | recoverReq_reg;

  // Detect the end of a short or brownout
  always_ff @(posedge clock) begin
    if (reset) begin
      resetFaultPrev_reg <= 1'b0;
      recoverReq_reg <= 1'b0;
    end else begin
      resetFaultPrev_reg <= resetFaultNow;
      recoverReq_reg <= resetFaultPrev_reg & ~resetFaultNow;
    end
  end

  // ---------------------------------------------------------------
  // Register decode
  // ---------------------------------------------------------------
  logic wrEff; // Write that really lands
  logic rdEff; // Read that really returns data
  logic wrMode;
  logic wrLaunch;
  logic wrLoop;

  // Enable low: the front end still acks but nothing is touched
  assign wrEff = regReq.write & enablePin;
  assign rdEff = regReq.read & enablePin;
  assign wrMode = wrEff & (regReq.addr == hap_ctrl_pkg::ADDR_MODE_CONTROL);
  assign wrLaunch = wrEff & (regReq.addr == hap_ctrl_pkg::ADDR_LAUNCH_CONTROL);
  assign wrLoop = wrEff & (regReq.addr == hap_ctrl_pkg::ADDR_LOOP_CONTROL);

  // ---------------------------------------------------------------
  // Mode control
  // ---------------------------------------------------------------
  logic standby;
  logic active;
  logic modeIsEdge;
  logic modeIsLevel;
  logic modeIsInternal;

  assign standby = modeControl_reg[hap_ctrl_pkg::MODE_STANDBY_BIT];
  assign active = enablePin & ~standby & ~faultHold;
  assign modeIsInternal = modeControl_reg[2:0] == hap_ctrl_pkg::MODE_INTERNAL;
  assign modeIsEdge = modeControl_reg[2:0] == hap_ctrl_pkg::MODE_EDGE;
  assign modeIsLevel = modeControl_reg[2:0] == hap_ctrl_pkg::MODE_LEVEL;

  // Standby is set out of every reset
  always_ff @(posedge clock) begin
    if (coreReset) begin
      modeControl_reg <= hap_ctrl_pkg::MODE_RESET[6:0];
    end else if (wrMode) begin
      modeControl_reg <= regReq.wdata[6:0];
    end
  end

  // Soft reset lasts one cycle, then the bit reads back low
  always_ff @(posedge clock) begin
    if (statusReset) begin
      softResetReq_reg <= 1'b0;
    end else begin
      softResetReq_reg <= wrMode & regReq.wdata[hap_ctrl_pkg::MODE_RESET_BIT];
    end
  end

  // ---------------------------------------------------------------
  // Trigger and launch
  // ---------------------------------------------------------------
  logic trigLevel;
  logic trigRise;
  logic launchSw;
  logic launchRun;
  logic launchNext;

  hap_trig_sync uTrig (
    .clock(clock),
    .reset(reset),
    .pinIn(triggerInputPin),
    .level(trigLevel),
    .rise(trigRise)
  );

  // Software write first, then a trigger rise toggles, then done clears
  assign launchSw = wrLaunch ? regReq.wdata[0] :
                    (modeIsEdge & trigRise) ? ~launch_reg :
                    sequenceDone ? 1'b0 : launch_reg;
  // Level mode follows the pin and nothing else
  assign launchRun = modeIsLevel ? trigLevel : launchSw;
  // Standby, shutdown or a fault stop playback at once
  assign launchNext = active ? launchRun : 1'b0;

  // Launch bit doubles as the run request
  always_ff @(posedge clock) begin
    if (coreReset) begin
      launch_reg <= 1'b0;
    end else begin
      launch_reg <= launchNext;
    end
  end

  // ---------------------------------------------------------------
  // Loop control and noise gate
  // ---------------------------------------------------------------
  logic [7:0] gateFloor;

  assign gateFloor = (loopControl_reg[1:0] == 2'h1) ? hap_ctrl_pkg::GATE_FLOOR_1 :
                     (loopControl_reg[1:0] == 2'h2) ? hap_ctrl_pkg::GATE_FLOOR_2 :
                     (loopControl_reg[1:0] == 2'h3) ? hap_ctrl_pkg::GATE_FLOOR_3 : 8'h00;

  // Plain read/write loop settings
  always_ff @(posedge clock) begin
    if (coreReset) begin
      loopControl_reg <= hap_ctrl_pkg::LOOP_RESET;
    end else if (wrLoop) begin
      loopControl_reg <= regReq.wdata;
    end
  end

  // Small levels are line noise, not intent
  always_ff @(posedge clock) begin
    if (coreReset) begin
      gatedLevel_reg <= 8'h00;
    end else begin
      gatedLevel_reg <= (inputLevel < gateFloor) ? 8'h00 : inputLevel;
    end
  end

  // ---------------------------------------------------------------
  // Supply measurement
  // ---------------------------------------------------------------

  // Sampled only while playing; holds the last value otherwise
  always_ff @(posedge clock) begin
    if (coreReset) begin
      supplyReading_reg <= 8'h00;
    end else if (launch_reg) begin
      supplyReading_reg <= supplyLevel;
    end
  end

  // ---------------------------------------------------------------
  // OTP-backed configuration
  // ---------------------------------------------------------------

  // One cycle after any reset the OTP image replaces the defaults
  // Held high through reset itself, or the power-up reload would be missed
  always_ff @(posedge clock) begin
    if (reset) begin
      otpLoad_reg <= 1'b1;
    end else begin
      otpLoad_reg <= coreReset;
    end
  end

  for (genvar g = 0; g < hap_ctrl_pkg::CFG_COUNT; g++) begin : gCfg
    // One settings byte
    always_ff @(posedge clock) begin
      if (coreReset) begin
        cfg_reg[g] <= hap_ctrl_pkg::CFG_RESET[8*g +: 8];
      end else if (otpLoad_reg && otpProgrammed) begin
        cfg_reg[g] <= otpImage[8*g +: 8];
      end else if (wrEff && regReq.addr == hap_ctrl_pkg::ADDR_CFG_FIRST + 8'(g)) begin
        cfg_reg[g] <= regReq.wdata;
      end
    end
    assign configImage[8*g +: 8] = cfg_reg[g];
  end

  // ---------------------------------------------------------------
  // Fault status
  // ---------------------------------------------------------------
  logic [1:0] faultSet;
  logic [1:0] faultClear;

  assign faultSet = {faultIn.overTemp, faultIn.outputShort};
  assign faultClear = (rdEff && regReq.addr == hap_ctrl_pkg::ADDR_FAULT_STATUS) ? 2'h3 : 2'h0;

  // Sticky until read; a new event wins over the clear
  always_ff @(posedge clock) begin
    if (statusReset) begin
      faultStatus_reg <= 2'h0;
    end else begin
      faultStatus_reg <= (faultStatus_reg & ~faultClear) | faultSet;
    end
  end

  // ---------------------------------------------------------------
  // Read path
  // ---------------------------------------------------------------
  logic [2:0] cfgIdx;
  logic [7:0] readMux;

  assign cfgIdx = 3'(regReq.addr - hap_ctrl_pkg::ADDR_CFG_FIRST);
  // Unmapped addresses read as zero
  assign readMux =
    (regReq.addr == hap_ctrl_pkg::ADDR_FAULT_STATUS) ? {6'h00, faultStatus_reg} :
    (regReq.addr == hap_ctrl_pkg::ADDR_MODE_CONTROL) ? {softResetReq_reg, modeControl_reg} :
    (regReq.addr == hap_ctrl_pkg::ADDR_LAUNCH_CONTROL) ? {7'h00, launch_reg} :
    (regReq.addr == hap_ctrl_pkg::ADDR_LOOP_CONTROL) ? loopControl_reg :
    (regReq.addr == hap_ctrl_pkg::ADDR_SUPPLY) ? supplyReading_reg :
    isCfg(regReq.addr) ? cfg_reg[cfgIdx] : 8'h00;

  // A read with enable low answers zero
  always_ff @(posedge clock) begin
    if (reset) begin
      regReadData_reg <= 8'h00;
    end else if (regReq.read) begin
      regReadData_reg <= rdEff ? readMux : 8'h00;
    end
  end

  // ---------------------------------------------------------------
  // Power state
  // ---------------------------------------------------------------
  hap_ctrl_pkg::hap_power_e powerNext;

  assign powerNext = faultHold ? hap_ctrl_pkg::PWR_FAULT :
                     !enablePin ? hap_ctrl_pkg::PWR_SHUTDOWN :
                     standby ? hap_ctrl_pkg::PWR_STANDBY :
                     launchNext ? hap_ctrl_pkg::PWR_PLAYING : hap_ctrl_pkg::PWR_READY;

  // Reported state
  always_ff @(posedge clock) begin
    if (coreReset) begin
      powerState_reg <= hap_ctrl_pkg::PWR_STANDBY;
    end else begin
      case (powerNext)
        hap_ctrl_pkg::PWR_SHUTDOWN: powerState_reg <= hap_ctrl_pkg::PWR_SHUTDOWN;
        hap_ctrl_pkg::PWR_STANDBY: powerState_reg <= hap_ctrl_pkg::PWR_STANDBY;
        hap_ctrl_pkg::PWR_READY: powerState_reg <= hap_ctrl_pkg::PWR_READY;
        hap_ctrl_pkg::PWR_PLAYING: powerState_reg <= hap_ctrl_pkg::PWR_PLAYING;
        default: powerState_reg <= hap_ctrl_pkg::PWR_FAULT;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // I2C hang watchdog
  // ---------------------------------------------------------------

  // Standby disarms it, so a hang there needs a power cycle
  hap_i2c_wdog #(
    .TIMEOUT(HANG_TIMEOUT_CYCLES)
  ) uWdog (
    .clock(clock),
    .reset(reset),
    .armed(~standby),
    .busy(i2cBusy),
    .hangReset(i2cProtocolReset)
  );

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign regReadData = regReadData_reg;
  assign playbackRun = launch_reg;
  assign gatedLevel = gatedLevel_reg;
  assign modeControl = {softResetReq_reg, modeControl_reg};
  assign loopControl = loopControl_reg;
  assign powerState = powerState_reg;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (reset);

  sequence softResetWrite;
    wrMode && regReq.wdata[hap_ctrl_pkg::MODE_RESET_BIT];
  endsequence

  sequence defaultsBack;
    softResetReq_reg ##1 (modeControl_reg == hap_ctrl_pkg::MODE_RESET[6:0] && !launch_reg);
  endsequence

  launch_write_a: assert property (
    wrLaunch && modeIsInternal && active && !coreReset |=> launch_reg == $past(regReq.wdata[0]))
    else $error("launch bit did not take written value");

  edge_toggle_a: assert property (
    modeIsEdge && trigRise && !wrLaunch && active && !coreReset |=> launch_reg != $past(launch_reg))
    else $error("edge rise did not toggle launch");

  edge_fall_a: assert property (
    modeIsEdge && !trigRise && !wrLaunch && !sequenceDone && active && !coreReset |=> $stable(launch_reg))
    else $error("launch moved without rise");

  level_track_a: assert property (
    modeIsLevel && active && !coreReset |=> launch_reg == $past(trigLevel))
    else $error("launch not tracking trigger level");

  standby_stop_a: assert property (standby |=> !launch_reg)
    else $error("playback running in standby");

  soft_reset_a: assert property (softResetWrite |=> defaultsBack)
    else $error("soft reset did not restore defaults");

  short_restart_a: assert property (
    resetFaultPrev_reg && !resetFaultNow |=> ##1 modeControl_reg == hap_ctrl_pkg::MODE_RESET[6:0])
    else $error("no restart after fault removal");

  thermal_flag_a: assert property (
    faultIn.overTemp && !statusReset |=> faultStatus_reg[hap_ctrl_pkg::FAULT_THERM_BIT] && !launch_reg)
    else $error("thermal flag missing");

  enable_gate_a: assert property (
    regReq.write && !enablePin && !coreReset |=> $stable(loopControl_reg))
    else $error("register written with enable low");

  supply_sample_a: assert property (
    launch_reg && !coreReset |=> supplyReading_reg == $past(supplyLevel))
    else $error("supply not sampled during playback");

  noise_gate_a: assert property (
    inputLevel < gateFloor && !coreReset |=> gatedLevel_reg == 8'h00)
    else $error("noise gate passed small level");

endmodule // hap_ctrl_top

//--- hw/hap_i2c_wdog.sv
// Purpose: Frees a hung I2C protocol engine
// Assumes: busy is high while a transfer is open
// Notes: Disarmed in standby
module hap_i2c_wdog #(
  parameter int TIMEOUT = 216500
) (
  // Clock and reset
  input wire logic clock,
  input wire logic reset,
  // Control
  input wire logic armed,
  input wire logic busy,
  // Recovery pulse
  output logic hangReset
);

  localparam int CW = $clog2(TIMEOUT + 1);
  localparam logic [CW-1:0] LAST = CW'(TIMEOUT - 1);

  // ---------------------------------------------------------------
  // Stall counter
  // ---------------------------------------------------------------
  logic [CW-1:0] count_reg;
  logic hang_reg;
  logic expire;

  assign expire = armed & busy & (count_reg == LAST);

  // Counts only an open transfer; any idle cycle restarts it
  always_ff @(posedge clock) begin
    if (reset || !armed || !busy || expire) begin
      count_reg <= '0;
    end else begin
      count_reg <= count_reg + CW'(1);
    end
  end

  // One-cycle reset of the protocol engine
  always_ff @(posedge clock) begin
    if (reset) begin
      hang_reg <= 1'b0;
    end else begin
      hang_reg <= expire;
    end
  end

  assign hangReset = hang_reg;

  hang_timeout_a: assert property (@(posedge clock) disable iff (reset)
    hang_reg |-> $past(busy) && $past(count_reg) == LAST)
    else $error("hang reset without full stall");

endmodule // hap_i2c_wdog

//--- hw/hap_trig_sync.sv
// Purpose: Brings the trigger pin into the clock domain
// Assumes: Pin is asynchronous to the clock
// Notes: Rise pulse is one cycle wide
module hap_trig_sync (
  // Clock and reset
  input wire logic clock,
  input wire logic reset,
  // Pin side
  input wire logic pinIn,
  // Core side
  output logic level,
  output logic rise
);

  // ---------------------------------------------------------------
  // Two-stage synchroniser plus edge stage
  // ---------------------------------------------------------------
  logic meta_reg; // First stage, read by second stage only
  logic sync_reg; // Settled level
  logic prev_reg; // Delayed copy for edge detection

  // Shift chain; edge logic looks only at settled stages
  always_ff @(posedge clock) begin
    if (reset) begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
      prev_reg <= 1'b0;
    end else begin
      meta_reg <= pinIn;
      sync_reg <= meta_reg;
      prev_reg <= sync_reg;
    end
  end

  assign level = sync_reg;
  assign rise = sync_reg & ~prev_reg;

  // Rise only after a settled low
  rise_shape_a: assert property (@(posedge clock) disable iff (reset)
    rise |-> $past(sync_reg) == 1'b0 && sync_reg)
    else $error("trigger rise without settled low");

endmodule // hap_trig_sync

//--- verif/hap_ctrl_top_tb.sv
// Purpose: Self-checking bench of the haptic control block
// Assumes: Watchdog timeout shortened to 20 cycles
// Notes: OTP programmed only in the reload test
module hap_ctrl_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock = 1'b0, reset = 1'b1, enablePin = 1'b1, busy = 1'b0, seqDone = 1'b0, fire = 1'b0, trig;
  logic [7:0] inLevel = 8'h07, rdData, gated, hold = 8'h32;
  hap_ctrl_pkg::hap_reg_req_s regReq = '0;
  hap_ctrl_pkg::hap_fault_s faultIn = '0;
  hap_ctrl_pkg::hap_power_e pwr;
  logic run, hangPulse, otpProg = 1'b0;
  logic [7:0] supply = 8'h5a, modeCtl, loopCtl;
  logic [39:0] cfgImg;
  int fail_count = 0, compares = 0, hangs = 0;
  hap_ctrl_top #(.HANG_TIMEOUT_CYCLES(20)) dut_u (.clock(clock), .reset(reset), .enablePin(enablePin),
    .triggerInputPin(trig), .regReq(regReq), .i2cBusy(busy), .regReadData(rdData),
    .i2cProtocolReset(hangPulse), .sequenceDone(seqDone), .inputLevel(inLevel), .playbackRun(run),
    .gatedLevel(gated), .modeControl(modeCtl), .loopControl(loopCtl), .configImage(cfgImg), .powerState(pwr),
    .supplyLevel(supply), .faultIn(faultIn), .otpProgrammed(otpProg), .otpImage(40'h5e4d3c2ba1));
  hap_host_pin host_u (.clock(clock), .fire(fire), .holdCycles(hold), .pin(trig));
  initial forever #10 clock = ~clock;
  // Count recovery pulses from the hang watchdog
  always @(posedge clock) if (hangPulse === 1'b1) hangs++;
  task chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  task wt(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock) regReq <= '{1'b1, 1'b0, a, d};
    @(posedge clock) regReq <= '0;
  endtask
  task rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clock) regReq <= '{1'b0, 1'b1, a, 8'h00};
    @(posedge clock) regReq <= '0;
    wt(1);
    chk(rdData, e);
  endtask
  task pulse();
    @(posedge clock) fire <= 1'b1;
    @(posedge clock) fire <= 1'b0;
  endtask
  // Software launch, cancel, completion and standby abort
  task t_launch();
    rd(8'h01, 8'h40);
    wr(8'h01, 8'h00);
    wt(2);
    chk({5'h0, pwr}, 8'h02);
    wr(8'h0c, 8'h01);
    wt(1);
    chk({7'h0, run}, 8'h01);
    rd(8'h21, 8'h5a);
    wr(8'h21, 8'h00);
    rd(8'h21, 8'h5a);
    rd(8'h0c, 8'h01);
    @(posedge clock) seqDone <= 1'b1;
    @(posedge clock) seqDone <= 1'b0;
    wt(2);
    chk({7'h0, run}, 8'h00);
    wr(8'h0c, 8'h01);
    wr(8'h0c, 8'h00);
    wt(1);
    chk({7'h0, run}, 8'h00);
    wr(8'h0c, 8'h01);
    wr(8'h01, 8'h40);
    wt(2);
    chk({7'h0, run}, 8'h00);
    @(posedge clock) supply <= 8'h11;
    wt(2);
    rd(8'h21, 8'h5a);
    $display("launch test done");
  endtask
  // Edge and level trigger modes through the pin
  task t_trigger();
    wr(8'h01, 8'h01);
    pulse();
    wt(8);
    chk({7'h0, run}, 8'h01);
    rd(8'h0c, 8'h01);
    wt(60);
    chk({7'h0, run}, 8'h01);
    pulse();
    wt(8);
    chk({7'h0, run}, 8'h00);
    @(posedge clock) hold <= 8'h64;
    wr(8'h01, 8'h02);
    pulse();
    wt(10);
    chk({7'h0, run}, 8'h01);
    wt(100);
    chk({7'h0, run}, 8'h00);
    $display("trigger test done");
  endtask
  // Gate, watchdog, thermal fault, enable and soft reset
  task t_misc();
    wr(8'h1d, 8'h02);
    wt(3);
    chk(gated, 8'h00);
    @(posedge clock) inLevel <= 8'h09;
    wt(3);
    chk(gated, 8'h09);
    @(posedge clock) busy <= 1'b1;
    wt(25);
    @(posedge clock) busy <= 1'b0;
    chk(hangs[7:0], 8'h01);
    @(posedge clock) faultIn.overTemp <= 1'b1;
    wt(3);
    chk({5'h0, pwr}, 8'h04);
    @(posedge clock) faultIn.overTemp <= 1'b0;
    rd(8'h00, 8'h02);
    @(posedge clock) enablePin <= 1'b0;
    wt(3);
    chk({5'h0, pwr}, 8'h00);
    wr(8'h1d, 8'h03);
    rd(8'h1d, 8'h00);
    @(posedge clock) enablePin <= 1'b1;
    rd(8'h1d, 8'h02);
    wr(8'h01, 8'h80);
    wt(3);
    rd(8'h01, 8'h40);
    rd(8'h1d, 8'h00);
    @(posedge clock) busy <= 1'b1;
    wt(30);
    @(posedge clock) busy <= 1'b0;
    chk(hangs[7:0], 8'h01);
    $display("misc test done");
  endtask
  // One restarting fault: raise it, drop it, expect defaults back
  task flt(input logic [3:0] f);
    wr(8'h01, 8'h00);
    wr(8'h1d, 8'h01);
    @(posedge clock) faultIn <= f;
    wt(2);
    chk({5'h0, pwr}, 8'h04);
    @(posedge clock) faultIn <= '0;
    wt(3);
    chk(loopCtl, 8'h00);
    chk(modeCtl, 8'h40);
  endtask
  // Output short, regulator short and brownout restarts
  task t_fault();
    flt(4'h4);
    rd(8'h00, 8'h01);
    flt(4'h2);
    flt(4'h1);
    $display("fault test done");
  endtask
  // OTP reload across a hard reset, then a write over a loaded byte
  task t_otp();
    @(posedge clock) otpProg <= 1'b1;
    reset <= 1'b1;
    repeat (2) @(posedge clock);
    reset <= 1'b0;
    wt(2);
    chk(cfgImg[39:32], 8'h5e);
    rd(8'h16, 8'ha1);
    chk(modeCtl, 8'h40);
    wr(8'h17, 8'h33);
    wt(1);
    chk(cfgImg[15:8], 8'h33);
    $display("otp test done");
  endtask
  task stop_test();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge clock);
    reset <= 1'b0;
    t_launch();
    t_trigger();
    t_misc();
    t_fault();
    t_otp();
    stop_test();
  end
  // Hang guard, well beyond the expected run length
  initial begin
    #200000;
    fail_count++;
    stop_test();
  end
endmodule // hap_ctrl_top_tb

//--- verif/hap_host_pin.sv
// Purpose: Host side of the trigger pin
// Assumes: Pulses are commanded by the bench
// Notes: Hold is stretched to the 1 us detect window
module hap_host_pin (
  // Clock
  input wire logic clock,
  // Pulse command
  input wire logic fire,
  input wire logic [7:0] holdCycles,
  // Trigger pin
  output logic pin
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] cnt = 8'h00; // Remaining high cycles
  // Short pulses would be missed by the synchroniser, so never under 50 cycles
  always_ff @(posedge clock) begin
    if (fire) begin
      cnt <= (holdCycles < 8'h32) ? 8'h32 : holdCycles;
    end else if (cnt != 8'h00) begin
      cnt <= cnt - 8'h01;
    end
  end
  assign pin = (cnt != 8'h00);
endmodule // hap_host_pin
